/* hw/swr_sequencer.sv */
// Suspend, remote wake and reset start-up sequencer of the serial bridge
`timescale 1ns/100ps

// Overview of operation
// - A wake command from the bus host ends suspend.
// - A low pulse on the active-low wake input is a remote wake trigger.
// - A rising edge on the ring indicator input is also a wake trigger.
// - Crystal interface is powered down while suspended.
// - After the clock restarts, wake inputs are sampled to confirm the event.
// - Device answers the host within 100 ms of power-up or attach; the sequencer only raises status.ready_late if not ready 70 ms after reset.
// - Configuration is loaded first, then firmware gets control if present.
module swr_sequencer
	import swr_pkg::*;
#(
	parameter int OSC_SETTLE   = OSC_SETTLE_CYC,
	parameter int READY_BUDGET = READY_BUDGET_CYC
)
(
	input  wire logic           clk,
	input  wire logic           sys_rst,
	input  wire logic           host_wake_cmd,
	input  wire logic           suspend_req,
	input  wire logic           wake_n,
	input  wire logic           ring_indicator_input,
	input  wire logic           cfg_load_done,
	input  wire logic           fw_present,
	output logic                osc_enable,
	output logic                cfg_load_start,
	output logic                fw_start,
	output logic                wake_event,
	output swr_status_type      status
);

	// ************************************************************
	// Synchronisers
	// ************************************************************
	logic [1:0]    wake_sync;
	logic [1:0]    ring_sync;
	logic          ring_prev;
	logic          host_wake;
	logic          cfg_sent;
	logic [31:0]   cnt;
	logic [31:0]   boot_cnt;
	swr_state_type state;
	swr_state_type next_state;
	logic          wake_seen;
	logic          wake_valid;

	// Both pins are asynchronous; only bit 1 is read by logic
	// two-stage synchroniser
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wake_sync <= SYNC_WAKE_RST;
			ring_sync <= SYNC_RING_RST;
			ring_prev <= 1'b0;
		end
		else
		begin
			wake_sync <= {wake_sync[0], wake_n};
			ring_sync <= {ring_sync[0], ring_indicator_input};
			ring_prev <= ring_sync[1];
		end
	end

	// Host command is caught so that it survives the oscillator restart
	// host wake latch
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			host_wake <= 1'b0;
		else if (host_wake_cmd)
			host_wake <= 1'b1;       // Set wins over the clear below
		else if (state == ST_VERIFY || state == ST_RUN)
			host_wake <= 1'b0;
	end

	assign wake_seen = !wake_sync[1] || (ring_sync[1] && !ring_prev) || host_wake_cmd;

	// Ring is checked by level here, its edge may have come while the clock was stopped
	// confirm wake event
	assign wake_valid = host_wake || !wake_sync[1] || ring_sync[1];

	// ************************************************************
	// Sequence
	// ************************************************************
	// Next state of the start-up and suspend sequence
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_BOOT_CFG:
			begin
				if (cfg_sent && cfg_load_done)
					next_state = fw_present ? ST_BOOT_FW : ST_RUN;
			end
			ST_BOOT_FW:
				next_state = ST_RUN;
			ST_RUN:
			begin
				if (suspend_req && !host_wake_cmd)
					next_state = ST_SUSPEND;
			end
			ST_SUSPEND:
			begin
				if (wake_seen)
					next_state = ST_OSC_WAIT;
			end
			ST_OSC_WAIT:
			begin
				if (cnt >= 32'(OSC_SETTLE - 1))
					next_state = ST_VERIFY;
			end
			ST_VERIFY:
				next_state = wake_valid ? ST_RUN : ST_SUSPEND;
			default:
				next_state = ST_BOOT_CFG;
		endcase
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			state <= ST_BOOT_CFG;
		else
			state <= next_state;
	end

	// Settle counter runs only while the crystal restarts
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt <= CNT_RST;
		else if (state == ST_OSC_WAIT)
			cnt <= cnt + 32'h0000_0001;
		else
			cnt <= CNT_RST;
	end

	// Crystal interface follows the next state so it drops with suspend entry
	// oscillator off in suspend
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			osc_enable <= 1'b1;
		else
			osc_enable <= (next_state != ST_SUSPEND);
	end

	// ************************************************************
	// Boot hand-over
	// ************************************************************
	// One load request per reset, then firmware start if present
	// ordered boot pulses
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfg_sent       <= 1'b0;
			cfg_load_start <= 1'b0;
			fw_start       <= 1'b0;
		end
		else
		begin
			cfg_sent       <= cfg_sent | (state == ST_BOOT_CFG);
			cfg_load_start <= (state == ST_BOOT_CFG) && !cfg_sent;
			fw_start       <= (state == ST_BOOT_CFG) && (next_state == ST_BOOT_FW);
		end
	end

	// Counts from reset release; the flag stays until the next reset
	// readiness budget
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			boot_cnt <= CNT_RST;
		else if (!status.ready && !status.ready_late)
			boot_cnt <= boot_cnt + 32'h0000_0001;
	end

	// Status and wake pulse
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			status     <= STATUS_RST;
			wake_event <= 1'b0;
		end
		else
		begin
			status.suspended  <= (next_state == ST_SUSPEND) || (next_state == ST_OSC_WAIT)
				|| (next_state == ST_VERIFY);
			status.ready      <= status.ready || (next_state == ST_RUN);
			status.ready_late <= status.ready_late || (!status.ready
				&& boot_cnt == 32'(READY_BUDGET - 1));
			wake_event        <= (state == ST_VERIFY) && wake_valid;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_host_wake_exit: assert property (
		(state == ST_SUSPEND && host_wake_cmd) |=> (state == ST_OSC_WAIT))
		else $error("host wake did not leave suspend");

	a_wake_pin_exit: assert property (
		(state == ST_SUSPEND && !wake_sync[1]) |=> (state == ST_OSC_WAIT) ##1 osc_enable)
		else $error("wake pin did not leave suspend");

	a_ring_edge_exit: assert property (
		(state == ST_SUSPEND && ring_sync[1] && !ring_prev) |=> (state == ST_OSC_WAIT))
		else $error("ring rise did not leave suspend");

	a_osc_off_suspend: assert property (
		(state == ST_SUSPEND) |-> (!osc_enable && status.suspended))
		else $error("oscillator on during suspend");

	a_verify_outcome: assert property (
		(state == ST_VERIFY) |=> (wake_event ? state == ST_RUN : state == ST_SUSPEND))
		else $error("wake verify outcome wrong");

	a_budget_flag: assert property (
		(!status.ready && !status.ready_late && boot_cnt == 32'(READY_BUDGET - 1))
		|=> status.ready_late)
		else $error("readiness deadline not flagged");

	a_cfg_before_fw: assert property (
		fw_start |-> ($past(cfg_load_done) && $past(state) == ST_BOOT_CFG && !status.ready))
		else $error("firmware started before configuration");

	a_sync_depth: assert property (
		(state == ST_SUSPEND && !wake_sync[1]) |-> !$past(wake_n, 2))
		else $error("wake pin used before two stages");

endmodule

/* hw/swr_pkg.sv */
// Shared constants, states and carriers of the suspend, wake and reset sequencer
package swr_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ         = 200;
	// Crystal interface settling after restart, kept under the 3 ms wake hold
	localparam int OSC_SETTLE_US   = 2000;
	localparam int OSC_SETTLE_CYC  = OSC_SETTLE_US * CLK_MHZ;
	// Share of the 100 ms readiness budget left after reset release
	localparam int READY_BUDGET_MS = 70;
	localparam int READY_BUDGET_CYC = READY_BUDGET_MS * 1000 * CLK_MHZ;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [1:0] SYNC_WAKE_RST = 2'h3;
	localparam logic [1:0] SYNC_RING_RST = 2'h0;
	localparam logic [31:0] CNT_RST      = 32'h0000_0000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		ST_BOOT_CFG = 3'b000,
		ST_BOOT_FW  = 3'b001,
		ST_RUN      = 3'b010,
		ST_SUSPEND  = 3'b011,
		ST_OSC_WAIT = 3'b100,
		ST_VERIFY   = 3'b101
	} swr_state_type;

	typedef struct packed {
		logic suspended;
		logic ready;
		logic ready_late;
	} swr_status_type;

	localparam swr_status_type STATUS_RST = '{suspended: 1'b0, ready: 1'b0, ready_late: 1'b0};

endpackage

/* verification/swr_wake_model.sv */
// Model of the outside drivers of the wake and ring indicator pins
`timescale 1ns/100ps
module swr_wake_model
(
	input  wire logic clk,
	output logic      wake_n,
	output logic      ring_indicator_input
);
	// Pulled-up wake pin, ring line idle low
	initial
	begin
		wake_n = 1'b1;
		ring_indicator_input = 1'b0;
	end

	task automatic drive(input bit ring, input int hold);
		@(posedge clk);
		if (ring)
			ring_indicator_input <= 1'b1;
		else
			wake_n <= 1'b0;
		repeat (hold) @(posedge clk);
		wake_n <= 1'b1;
		ring_indicator_input <= 1'b0;
	endtask
endmodule

/* verification/swr_sequencer_tb.sv */
// Self-checking bench of the suspend, wake and reset sequencer
`timescale 1ns/100ps
module swr_sequencer_tb
	import swr_pkg::*;
;
	// ************************************************************
	// Stimulus and design
	// ************************************************************
	logic           clk = 1'b0;
	logic           sys_rst = 1'b1;
	logic           host_wake_cmd = 1'b0;
	logic           suspend_req = 1'b0;
	logic           cfg_load_done = 1'b0;
	logic           fw_present = 1'b1;
	logic           wake_n;
	logic           ring_indicator_input;
	logic           osc_enable;
	logic           cfg_load_start;
	logic           fw_start;
	logic           wake_event;
	swr_status_type status;
	int             failures = 0;
	int             comparisons = 0;
	// Short readiness budget in cycles, also the expectation of the late boot test
	localparam int  SIM_BUDGET = 200;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// Short settle and budget keep the run brief
	swr_sequencer #(.OSC_SETTLE(8), .READY_BUDGET(SIM_BUDGET)) swr_sequencer_i (
		.clk(clk), .sys_rst(sys_rst), .host_wake_cmd(host_wake_cmd),
		.suspend_req(suspend_req), .wake_n(wake_n),
		.ring_indicator_input(ring_indicator_input), .cfg_load_done(cfg_load_done),
		.fw_present(fw_present), .osc_enable(osc_enable), .cfg_load_start(cfg_load_start),
		.fw_start(fw_start), .wake_event(wake_event), .status(status));

	swr_wake_model swr_wake_model_i (.clk(clk), .wake_n(wake_n),
		.ring_indicator_input(ring_indicator_input));

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic check(input logic [2:0] seen, input logic [2:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t: seen %b expected %b", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic enter_suspend;
		@(posedge clk);
		suspend_req <= 1'b1;
		@(posedge clk);
		suspend_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(osc_enable, 1'b0);
		check(status.suspended, 1'b1);
	endtask

	// Window covers settle and verify with margin
	task automatic await_wake(input logic exp);
		logic got;
		got = 1'b0;
		repeat (40)
		begin
			@(posedge clk);
			#1;
			if (wake_event === 1'b1)
				got = 1'b1;
		end
		check(got, exp);
		check(osc_enable, exp);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic test_boot;
		int n;
		n = 0;
		while (cfg_load_start !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check(cfg_load_start, 1'b1);
		check(status.ready, 1'b0);
		@(posedge clk);
		cfg_load_done <= 1'b1;
		@(posedge clk);
		cfg_load_done <= 1'b0;
		#1;
		check(fw_start, 1'b1);
		@(posedge clk);
		#1;
		check(status.ready, 1'b1);
		$display("Boot test done");
	endtask

	// Pulse too short to survive verification
	task automatic test_short_pulse;
		enter_suspend();
		fork
			swr_wake_model_i.drive(1'b0, 2);
		join_none
		await_wake(1'b0);
		$display("Short pulse test done");
	endtask

	task automatic test_host_wake;
		@(posedge clk);
		host_wake_cmd <= 1'b1;
		@(posedge clk);
		host_wake_cmd <= 1'b0;
		await_wake(1'b1);
		$display("Host wake test done");
	endtask

	task automatic test_pin_wake(input bit ring);
		enter_suspend();
		fork
			swr_wake_model_i.drive(ring, 20);
		join_none
		await_wake(1'b1);
		$display("Pin wake test done");
	endtask

	// Second reset mid-run; a late load trips the readiness flag, no firmware to start
	task automatic test_late_boot;
		@(posedge clk);
		sys_rst <= 1'b1;
		fw_present <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(status, 3'b000);
		check(osc_enable, 1'b1);
		repeat (10) @(posedge clk);
		// reset held with the clock running
		sys_rst <= 1'b0;
		repeat (SIM_BUDGET - 1) @(posedge clk);
		#1;
		check(status, 3'b000);
		@(posedge clk);
		#1;
		check(status, 3'b001);
		@(posedge clk);
		cfg_load_done <= 1'b1;
		@(posedge clk);
		cfg_load_done <= 1'b0;
		#1;
		check(fw_start, 1'b0);
		check(status, 3'b011);
		$display("Late boot test done");
	endtask

	// ************************************************************
	// Sequence and watchdog
	// ************************************************************
	initial
	begin
		repeat (12) @(posedge clk);
		// reset held with the clock running
		sys_rst <= 1'b0;
		test_boot();
		test_short_pulse();
		test_host_wake();
		test_pin_wake(1'b0);
		test_pin_wake(1'b1);
		check(status.ready_late, 1'b0);
		test_late_boot();
		tally_and_finish();
	end

	// About five times the expected run length
	initial
	begin
		repeat (2000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
endmodule
